// ---- hw/block_protection_command_unit.sv ----
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
// Operation
// - status and password steps are reads
// - enter sequence precedes every protection operation
// - one program command per password word
// - only exit sequence leaves command set
// - enter: AA@555, 55@2AA, code@555
module block_protection_command_unit
	import bpc_pkg::*;
#(
	parameter int SUSPEND_LIMIT = SUSPEND_CYC
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// flash pins
	output flash_ctl_t flash_o,
	output logic [DATA_W-1:0] dq_o,
	output logic dq_oe_o,
	input wire logic [DATA_W-1:0] dq_i
);
	initial assert (SUSPEND_LIMIT >= 1);
	////////////////////////////////////////////////////////////////////////
	// software registers
	logic [31:0] ctrl_q; // op, mode code, go
	logic [ADDR_W-1:0] addr_q; // target address
	logic [DATA_W-1:0] wdata_q; // program data
	logic [DATA_W-1:0] rdata_q; // last read data
	logic busy_q; // sequence running
	logic in_set_q; // a command set is entered
	logic [7:0] mode_q; // which command set
	logic refused_q; // request was not legal
	logic [3:0] pwd_seen_q; // password words touched
	logic aw_hold_q, w_hold_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_hold_q;
	// sequence engine
	typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} sstate_t;
	sstate_t seq_q;
	bus_cycle_t list_q [4]; // up to four bus cycles per command
	logic [2:0] len_q, idx_q;
	logic cyc_start_q;
	logic [DATA_W-1:0] cyc_rdata;
	logic cyc_done;
	flash_ctl_t ctl;
	logic [DATA_W-1:0] cyc_dq;
	logic cyc_oe;
	////////////////////////////////////////////////////////////////////////
	// decode
	wire op_t req_op = op_t'(ctrl_q[CTRL_OP_LSB +: 4]);
	wire write_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
	wire ctrl_wr = write_go && awaddr_q == OFS_CTRL;
	wire go = ctrl_wr && wdata_hold_q[CTRL_GO_BIT] && !busy_q;
	wire op_t go_op = op_t'(wdata_hold_q[CTRL_OP_LSB +: 4]);
	wire [7:0] go_mode = wdata_hold_q[CTRL_MODE_LSB +: 8];
	// block 0 gating is the device's job; every address passes through
	wire needs_set = go_op != OP_ENTER && go_op != OP_RESET;
	wire refuse = go && ((needs_set && !in_set_q)
		|| (go_op == OP_ENTER && in_set_q));
	// a command cycle: upper data byte kept zero, address passed through as given
	function automatic bus_cycle_t wr_cyc(input logic [ADDR_W-1:0] a,
		input logic [7:0] d);
		wr_cyc = '{wr: 1'b1, addr: a, data: {8'h00, d}};
	endfunction
	////////////////////////////////////////////////////////////////////////
	// axi write path: address and data taken in either order
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_hold_q <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_hold_q <= s_axi_wdata;
			end
			if (write_go) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign s_axi_awready = !aw_hold_q;
	assign s_axi_wready = !w_hold_q;
	assign s_axi_bresp = 2'b00;
	////////////////////////////////////////////////////////////////////////
	// register writes
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl_q <= 32'h0000_0000;
			addr_q <= '0;
			wdata_q <= '0;
		end else if (write_go) begin
			case (awaddr_q)
				OFS_CTRL: if (!busy_q) ctrl_q <= wdata_hold_q;
				OFS_ADDR: addr_q <= wdata_hold_q[ADDR_W-1:0];
				OFS_WDATA: wdata_q <= wdata_hold_q[DATA_W-1:0];
				default: ;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////
	// axi read path, one cycle answer
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			case (s_axi_araddr)
				OFS_CTRL: s_axi_rdata <= ctrl_q;
				OFS_ADDR: s_axi_rdata <= 32'(addr_q);
				OFS_WDATA: s_axi_rdata <= 32'(wdata_q);
				OFS_STATUS: s_axi_rdata <= {16'h0000, mode_q, pwd_seen_q,
					1'b0, refused_q, in_set_q, busy_q};
				OFS_RDATA: s_axi_rdata <= 32'(rdata_q);
				default: s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_rresp = 2'b00;
	////////////////////////////////////////////////////////////////////////
	// sequence builder and runner
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			seq_q <= S_IDLE;
			busy_q <= 1'b0;
			in_set_q <= 1'b0;
			mode_q <= 8'h00;
			refused_q <= 1'b0;
			pwd_seen_q <= 4'h0;
			len_q <= 3'h0;
			idx_q <= 3'h0;
			cyc_start_q <= 1'b0;
			rdata_q <= '0;
			for (int i = 0; i < 4; i++) list_q[i] <= '0;
		end else begin
			cyc_start_q <= 1'b0;
			case (seq_q)
				S_IDLE: begin
					if (refuse) begin
						refused_q <= 1'b1;
					end else if (go) begin
						refused_q <= 1'b0;
						busy_q <= 1'b1;
						idx_q <= 3'h0;
						seq_q <= S_ISSUE;
						case (go_op)
							OP_ENTER: begin
								list_q[0] <= wr_cyc(UNLOCK_ADDR1, UNLOCK_DATA1);
								list_q[1] <= wr_cyc(UNLOCK_ADDR2, UNLOCK_DATA2);
								list_q[2] <= wr_cyc(UNLOCK_ADDR1 |
									(addr_q & 23'h7F0000), go_mode);
								len_q <= 3'h3;
								mode_q <= go_mode;
								pwd_seen_q <= 4'h0;
							end
							OP_PROGRAM: begin
								list_q[0] <= wr_cyc('0, CMD_PROGRAM);
								list_q[1] <= '{wr: 1'b1, addr: addr_q,
									data: wdata_q};
								len_q <= 3'h2;
							end
							OP_READ: begin
								list_q[0] <= '{wr: 1'b0, addr: addr_q,
									data: '0};
								len_q <= 3'h1;
							end
							OP_CLEAR_ALL: begin
								list_q[0] <= wr_cyc('0, CMD_ERASE_SETUP);
								list_q[1] <= wr_cyc('0, CMD_CLEAR_ALL);
								len_q <= 3'h2;
							end
							OP_VOL_CLEAR: begin
								list_q[0] <= wr_cyc('0, CMD_PROGRAM);
								list_q[1] <= '{wr: 1'b1, addr: addr_q,
									data: {8'h00, DATA_UNLOCK}};
								len_q <= 3'h2;
							end
							OP_EXT_EXIT: begin
								list_q[0] <= wr_cyc(UNLOCK_ADDR1, UNLOCK_DATA1);
								list_q[1] <= wr_cyc(UNLOCK_ADDR2, UNLOCK_DATA2);
								list_q[2] <= wr_cyc(UNLOCK_ADDR1, CMD_EXIT1);
								list_q[3] <= wr_cyc('0, CMD_EXIT2);
								len_q <= 3'h4;
							end
							default: begin // exit and reset
								list_q[0] <= wr_cyc('0, CMD_EXIT1);
								list_q[1] <= wr_cyc('0, CMD_EXIT2);
								len_q <= 3'h2;
							end
						endcase
					end
				end
				S_ISSUE: begin
					cyc_start_q <= 1'b1;
					seq_q <= S_WAIT;
				end
				S_WAIT: begin
					if (cyc_done) begin
						if (!list_q[idx_q[1:0]].wr) rdata_q <= cyc_rdata;
						if (idx_q + 3'h1 < len_q) begin
							idx_q <= idx_q + 3'h1;
							seq_q <= S_ISSUE;
						end else begin
							busy_q <= 1'b0;
							seq_q <= S_IDLE;
							case (req_op)
								OP_ENTER: in_set_q <= 1'b1;
								OP_EXIT, OP_EXT_EXIT, OP_RESET:
									in_set_q <= 1'b0;
								OP_PROGRAM, OP_READ:
									if (mode_q == MODE_PASSWORD)
										pwd_seen_q[addr_q[1:0]] <= 1'b1;
								default: ;
							endcase
						end
					end
				end
				default: seq_q <= S_IDLE;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////
	// bus cycle engine
	flash_cycle u_cycle (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.start_i(cyc_start_q),
		.cyc_i(list_q[idx_q[1:0]]),
		.dq_i(dq_i),
		.ctl_o(ctl),
		.dq_o(cyc_dq),
		.dq_oe_o(cyc_oe),
		.rdata_o(cyc_rdata),
		.done_o(cyc_done)
	);
	// register pins once more so outputs leave from flip-flops
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			flash_o <= '{chip_en_n: 1'b1, out_en_n: 1'b1, wr_en_n: 1'b1,
				reset_n: 1'b0, addr: '0};
			dq_o <= '0;
			dq_oe_o <= 1'b0;
		end else begin
			flash_o <= ctl;
			dq_o <= cyc_dq;
			dq_oe_o <= cyc_oe;
		end
	end
endmodule // block_protection_command_unit

// ---- hw/bpc_pkg.sv ----
package bpc_pkg;
	// flash bus widths
	localparam int ADDR_W = 23;
	localparam int DATA_W = 16;
	// unlock pattern
	localparam logic [22:0] UNLOCK_ADDR1 = 23'h000555;
	localparam logic [22:0] UNLOCK_ADDR2 = 23'h0002AA;
	localparam logic [7:0] UNLOCK_DATA1 = 8'hAA;
	localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
	// mode codes written as third unlock cycle
	localparam logic [7:0] MODE_LOCK_REG = 8'h40;
	localparam logic [7:0] MODE_PASSWORD = 8'h60;
	localparam logic [7:0] MODE_NONVOL = 8'hC0;
	localparam logic [7:0] MODE_NV_LOCK_BIT = 8'h50;
	localparam logic [7:0] MODE_VOLATILE = 8'hE0;
	localparam logic [7:0] MODE_EXT_BLOCK = 8'h88;
	// command codes
	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CLEAR_ALL = 8'h30;
	localparam logic [7:0] CMD_EXIT1 = 8'h90;
	localparam logic [7:0] CMD_EXIT2 = 8'h00;
	localparam logic [7:0] DATA_LOCK = 8'h00;
	localparam logic [7:0] DATA_UNLOCK = 8'h01;
	// bus cycle timing: 100 ns clock, cycle phase lengths in ns
	localparam int CLK_NS = 100;
	localparam int SETUP_NS = 100;
	localparam int PULSE_NS = 100;
	localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	// program suspend longest latency
	localparam int SUSPEND_MAX_US = 15;
	localparam int SUSPEND_CYC = SUSPEND_MAX_US * 1000 / CLK_NS;
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_WDATA = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_RDATA = 8'h10;
	// control field positions
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_MODE_LSB = 8;
	localparam int CTRL_GO_BIT = 31;
	// operations
	typedef enum logic [3:0] {
		OP_ENTER, OP_EXIT, OP_PROGRAM, OP_READ, OP_CLEAR_ALL,
		OP_VOL_CLEAR, OP_EXT_EXIT, OP_RESET
	} op_t;
	// one flash bus cycle
	typedef struct packed {
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} bus_cycle_t;
	// flash pins driven by the controller
	typedef struct packed {
		logic chip_en_n;
		logic out_en_n;
		logic wr_en_n;
		logic reset_n;
		logic [ADDR_W-1:0] addr;
	} flash_ctl_t;
endpackage

// ---- hw/flash_cycle.sv ----
`timescale 1ns/1ns
// runs one asynchronous flash bus cycle, read or write
module flash_cycle
	import bpc_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic start_i,
	input wire bus_cycle_t cyc_i,
	input wire logic [DATA_W-1:0] dq_i,
	output flash_ctl_t ctl_o,
	output logic [DATA_W-1:0] dq_o,
	output logic dq_oe_o,
	output logic [DATA_W-1:0] rdata_o,
	output logic done_o
);
	typedef enum logic [1:0] {C_IDLE, C_SETUP, C_PULSE, C_HOLD} cstate_t;
	cstate_t state_q;
	logic [3:0] cnt_q;
	logic is_wr_q;
	////////////////////////////////////////////////////////////////////////
	// cycle sequencer: setup, strobe pulse, release
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= C_IDLE;
			cnt_q <= 4'h0;
			is_wr_q <= 1'b0;
			ctl_o <= '{chip_en_n: 1'b1, out_en_n: 1'b1, wr_en_n: 1'b1,
				reset_n: 1'b1, addr: '0};
			dq_o <= '0;
			dq_oe_o <= 1'b0;
			rdata_o <= '0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state_q)
				C_IDLE: begin
					if (start_i) begin
						// address and chip enable first
						ctl_o.addr <= cyc_i.addr;
						ctl_o.chip_en_n <= 1'b0;
						is_wr_q <= cyc_i.wr;
						dq_o <= cyc_i.data;
						dq_oe_o <= cyc_i.wr;
						cnt_q <= 4'(SETUP_CYC);
						state_q <= C_SETUP;
					end
				end
				C_SETUP: begin
					if (cnt_q > 4'h1) begin
						cnt_q <= cnt_q - 4'h1;
					end else begin
						// write strobe or output enable, never both
						ctl_o.wr_en_n <= ~is_wr_q;
						ctl_o.out_en_n <= is_wr_q;
						cnt_q <= 4'(PULSE_CYC);
						state_q <= C_PULSE;
					end
				end
				C_PULSE: begin
					if (cnt_q > 4'h1) begin
						cnt_q <= cnt_q - 4'h1;
					end else begin
						ctl_o.wr_en_n <= 1'b1;
						ctl_o.out_en_n <= 1'b1;
						state_q <= C_HOLD;
					end
				end
				C_HOLD: begin
					// pins lag one flop, so the strobe is still low at the
					// pins on this edge: read data is valid only now
					if (!is_wr_q) begin
						rdata_o <= dq_i;
					end
					// data held past the rising write edge
					ctl_o.chip_en_n <= 1'b1;
					dq_oe_o <= 1'b0;
					done_o <= 1'b1;
					state_q <= C_IDLE;
				end
				default: begin
					state_q <= C_IDLE;
				end
			endcase
		end
	end
endmodule // flash_cycle

// ---- sim/block_protection_command_unit_bench.sv ----
`timescale 1ns/1ns
module block_protection_command_unit_bench
	import bpc_pkg::*;
;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] awaddr = '0;
	logic [7:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] rdata;
	logic [1:0] bresp, rresp;
	flash_ctl_t pins;
	logic [15:0] dq_h; // controller drive
	logic [15:0] dq_f; // flash drive
	logic oe;
	wire [15:0] bus = oe ? dq_h : dq_f; // resolved data wire
	int n_fail = 0;
	int compares = 0;
	logic [31:0] r;
	localparam logic [7:0] MODES [5] = '{MODE_LOCK_REG, MODE_PASSWORD,
		MODE_NONVOL, MODE_NV_LOCK_BIT, MODE_VOLATILE};
	localparam logic [1:0] ORD [4] = '{2'd3, 2'd0, 2'd2, 2'd1};
	always #50 sys_clk_i = ~sys_clk_i;
	block_protection_command_unit #(.SUSPEND_LIMIT(4))
		u_block_protection_command_unit (.sys_clk_i, .reset_i,
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .flash_o(pins),
		.dq_o(dq_h), .dq_oe_o(oe), .dq_i(bus));
	flash_model u_flash_model (.pin_i(pins), .dq_i(bus), .dq_o(dq_f));
	////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ga;
		logic gw;
		ga = 1'b0;
		gw = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ga && gw)) begin
			@(posedge sys_clk_i);
			if (!ga && awready === 1'b1) begin
				ga = 1'b1;
				awvalid <= 1'b0;
			end
			if (!gw && wready === 1'b1) begin
				gw = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge sys_clk_i); while (bvalid !== 1'b1);
		chk("bresp", 16'h0, {14'h0, bresp});
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge sys_clk_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge sys_clk_i); while (rvalid !== 1'b1);
		d = rdata;
		chk("rresp", 16'h0, {14'h0, rresp});
	endtask
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one controller operation, polled until idle
	task automatic op(input op_t c, input logic [7:0] m,
		input logic [22:0] a, input logic [15:0] d);
		int n;
		wr(OFS_ADDR, {9'h0, a});
		wr(OFS_WDATA, {16'h0, d});
		wr(OFS_CTRL, {1'b1, 15'h0, m, 4'h0, c});
		n = 0;
		r = 32'h1;
		while (r[0] !== 1'b0 && n < 300) begin
			rd(OFS_STATUS, r);
			n++;
		end
		// a sequence that never finishes counts as a mismatch
		chk("idle", 16'h0, {15'h0, r[0]});
	endtask
	task automatic rw(input logic [22:0] a);
		op(OP_READ, '0, a, '0);
		rd(OFS_RDATA, r);
	endtask
	task automatic mchk(input logic [7:0] e);
		rd(OFS_STATUS, r);
		chk("in set", {15'h0, e != 8'h0}, {15'h0, r[1]});
		chk("dev mode", {8'h0, e}, {8'h0, u_flash_model.mode_q});
	endtask
	task automatic close_out;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// watchdog far beyond the expected few thousand cycles
	initial begin
		repeat (60000) @(posedge sys_clk_i);
		n_fail++;
		$display("BAD watchdog expected done seen hang");
		close_out;
	end
	initial begin
		repeat (4) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		@(posedge sys_clk_i);
		mchk(8'h00);
		rd(8'h20, r);
		chk("unmapped", 16'h0, r[15:0]);
		op(OP_PROGRAM, '0, '0, '0);
		chk("refused", 16'h1, {15'h0, r[2]});
		for (int i = 0; i < 5; i++) begin
			op(OP_ENTER, MODES[i], '0, '0);
			chk("mode", {MODES[i], 8'h02}, {r[15:8], 6'h0, r[1:0]});
			mchk(MODES[i]);
			op(OP_EXIT, '0, '0, '0);
			mchk(8'h00);
		end
		op(OP_ENTER, MODE_VOLATILE, '0, '0);
		op(OP_ENTER, MODE_NONVOL, '0, '0);
		chk("refused", 16'h1, {15'h0, r[2]});
		mchk(MODE_VOLATILE);
		rw(23'h050000);
		chk("open", 16'h0001, r[15:0]);
		op(OP_PROGRAM, '0, 23'h050000, '0);
		rw(23'h050000);
		chk("shut", 16'h0000, r[15:0]);
		op(OP_VOL_CLEAR, '0, 23'h050000, '0);
		rw(23'h050000);
		chk("reopen", 16'h0001, r[15:0]);
		op(OP_PROGRAM, '0, 23'h000100, '0);
		rw(23'h000100);
		chk("block 0", 16'h0000, r[15:0]);
		chk("block 0 bit", 16'h0001, {15'h0, u_flash_model.vol_q[0]});
		op(OP_EXIT, '0, '0, '0);
		op(OP_ENTER, MODE_NONVOL, '0, '0);
		op(OP_PROGRAM, '0, 23'h060000, '0);
		rw(23'h060000);
		chk("nv shut", 16'h0000, r[15:0]);
		op(OP_CLEAR_ALL, '0, '0, '0);
		rw(23'h060000);
		chk("nv open", 16'h0001, r[15:0]);
		op(OP_RESET, '0, '0, '0);
		mchk(8'h00);
		op(OP_ENTER, MODE_PASSWORD, '0, '0);
		for (int i = 0; i < 4; i++)
			op(OP_PROGRAM, '0, {21'h0, ORD[i]}, 16'h1357 + ORD[i]);
		for (int i = 0; i < 4; i++) begin
			rw(23'(i));
			chk("pwd word", 16'h1357 + 16'(i), r[15:0]);
		end
		rd(OFS_STATUS, r);
		chk("pwd seen", 16'h00F0, {8'h0, r[7:4], 4'h0});
		op(OP_EXIT, '0, '0, '0);
		op(OP_ENTER, MODE_EXT_BLOCK, '0, '0);
		op(OP_PROGRAM, '0, 23'h000010, 16'hBEEF);
		rw(23'h000010);
		chk("ext word", 16'hBEEF, r[15:0]);
		op(OP_EXT_EXIT, '0, '0, '0);
		mchk(8'h00);
		chk("ops done", 16'h000A, {8'h0, u_flash_model.ops_done_q});
		op(OP_ENTER, MODE_VOLATILE, '0, '0);
		reset_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		@(posedge sys_clk_i);
		mchk(8'h00);
		close_out;
	end
endmodule // block_protection_command_unit_bench

// ---- sim/block_protection_command_unit_checker.sv ----
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
// pin rules of the controller side, seen at its top ports
module block_protection_command_unit_checker
	import bpc_pkg::*;
#(
	parameter int SUSPEND_LIMIT = SUSPEND_CYC
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire flash_ctl_t flash_o,
	input wire logic [DATA_W-1:0] dq_o,
	input wire logic dq_oe_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	wire wr = !flash_o.wr_en_n; // write strobe active
	wire oe = !flash_o.out_en_n; // read strobe active
	a_strobes_apart: assert property (!(wr && oe))
		else $error("both strobes low");
	a_write_drives: assert property (wr |-> dq_oe_o)
		else $error("write without bus drive");
	a_read_released: assert property (oe |-> !dq_oe_o)
		else $error("bus driven during read");
	a_pulse_one: assert property ($rose(wr) |=> !wr)
		else $error("write strobe not one cycle");
	a_second_unlock: assert property (
		wr && flash_o.addr == UNLOCK_ADDR2 |-> dq_o == 16'h0055)
		else $error("bad second unlock word");
	a_first_unlock: assert property (
		wr && dq_o == 16'h00AA |-> flash_o.addr == UNLOCK_ADDR1)
		else $error("first unlock at wrong address");
	a_unlock_pair: assert property ($rose(wr) && dq_o == 16'h00AA
		|-> ##[1:20] (wr && dq_o == 16'h0055))
		else $error("unlock not followed by second word");
	// exit is two writes back to back; a lone first half hangs the set
	a_exit_pair: assert property ($rose(wr) && dq_o == 16'h0090
		|-> ##[1:20] (wr && dq_o == 16'h0000))
		else $error("exit not completed");
	a_reset_quiet: assert property (
		$fell(reset_i) |-> !wr && !oe && !dq_oe_o)
		else $error("pins active after reset");
	c_enter_vol: cover property (wr && dq_o == 16'h00E0);
	c_read: cover property (oe);
	c_reset: cover property ($fell(reset_i));
endmodule // block_protection_command_unit_checker
bind block_protection_command_unit block_protection_command_unit_checker
	#(.SUSPEND_LIMIT(SUSPEND_LIMIT)) u_chk (.sys_clk_i, .reset_i,
	.flash_o, .dq_o, .dq_oe_o);

// ---- sim/flash_model.sv ----
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
// pin-level flash, protection command sets only
module flash_model
	import bpc_pkg::*;
(
	input wire flash_ctl_t pin_i,
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o
);
	logic [7:0] mode_q; // zero is read mode
	logic [1:0] step_q; // unlock progress
	logic [1:0] cmd_q; // 1 program, 2 erase, 3 exit
	logic [127:0] vol_q; // one means open
	logic [127:0] nv_q; // one means open
	logic [15:0] pwd_q [4];
	logic [15:0] ext_q [256];
	logic [15:0] lock_q;
	logic [15:0] last_q;
	logic [15:0] rd;
	logic [7:0] ops_done_q; // finished programs and erases
	wire [7:0] cd = dq_i[7:0];
	wire [15:0] ca = pin_i.addr[15:0];
	wire [6:0] bk = pin_i.addr[22:16];
	wire lk = !nv_q[bk] || !vol_q[bk];
	// block 0 is walled off while a protection bit set is entered
	wire blk0 = bk == 7'd0
		&& (mode_q == MODE_VOLATILE || mode_q == MODE_NONVOL);
	// programs finish at the strobe, so a suspend never waits
	initial begin
		ops_done_q = '0;
		vol_q = '1;
		nv_q = '1;
		lock_q = '1;
		last_q = '0;
	end
	// writes land on the rising write strobe
	always @(posedge pin_i.wr_en_n or negedge pin_i.reset_n) begin
		if (!pin_i.reset_n) begin
			mode_q <= '0;
			step_q <= '0;
			cmd_q <= '0;
		end else if (!pin_i.chip_en_n) begin
			step_q <= '0;
			cmd_q <= '0;
			if (cmd_q == 2'd1) begin
				ops_done_q <= ops_done_q + 8'h01;
				if (mode_q == MODE_VOLATILE && !blk0)
					vol_q[bk] <= cd[0];
				if (mode_q == MODE_NONVOL && !blk0) nv_q[bk] <= 1'b0;
				if (mode_q == MODE_PASSWORD) pwd_q[ca[1:0]] <= dq_i;
				if (mode_q == MODE_EXT_BLOCK) ext_q[ca[7:0]] <= dq_i;
				if (mode_q == MODE_LOCK_REG) lock_q <= lock_q & dq_i;
			end else if (cmd_q == 2'd2) begin
				// program-all then erase ends with every nonvolatile bit open
				if (cd == CMD_CLEAR_ALL) begin
					nv_q <= '1;
					ops_done_q <= ops_done_q + 8'h01;
				end
			end else if (cmd_q == 2'd3) begin
				if (cd == CMD_EXIT2) mode_q <= '0;
			end else if (cd == UNLOCK_DATA1 && ca == 16'h0555) begin
				step_q <= 2'd1;
			end else if (step_q == 2'd1 && cd == UNLOCK_DATA2
				&& ca == 16'h02AA) begin
				step_q <= 2'd2;
			end else if (step_q == 2'd2 && ca == 16'h0555) begin
				if (cd == CMD_EXIT1) cmd_q <= 2'd3;
				else if (mode_q == '0) mode_q <= cd;
			end else if (mode_q != '0) begin
				if (cd == CMD_PROGRAM) cmd_q <= 2'd1;
				if (cd == CMD_ERASE_SETUP) cmd_q <= 2'd2;
				if (cd == CMD_EXIT1) cmd_q <= 2'd3;
			end
		end
	end
	// read data by mode
	always_comb begin
		if (mode_q == MODE_PASSWORD) rd = pwd_q[ca[1:0]];
		else if (mode_q == MODE_EXT_BLOCK) rd = ext_q[ca[7:0]];
		else if (mode_q == MODE_LOCK_REG) rd = lock_q;
		else if (blk0) rd = 16'h0000;
		else if (mode_q != '0) rd = {15'h0, !lk};
		else rd = ca ^ 16'h5A5A;
	end
	// a released bus shows the inverse, so stale data never matches
	always @(posedge pin_i.out_en_n) last_q <= rd;
	assign dq_o = !pin_i.out_en_n ? rd : ~last_q;
endmodule // flash_model
